//--- inc/sycc_pkg.sv
// Purpose: Constants for the sysref capture and calibration controller.
// Assumes: Register indices times four give the APB byte address.
// Notes: Long cycle counts are overridable module parameters.
// What this block does
// - Delay sysref by the 4-bit delay field before sampling.
// - Set a sticky edge-seen flag on each captured sysref rising edge.
// - Set a sticky failure flag when setup or hold margin is too small.
// - Clear bits in the capture control register clear the two sticky flags.
// - Control bits enable the sysref receiver and sysref processing separately.
// - With decimation active, reset NCO phase accumulators during lane alignment.
// - Decimation one bypasses down-conversion, giving raw 12-bit samples every cycle.
// - Larger factors 4, 8, 10, 16, 20, 32 give complex output at reduced rate.
// - Foreground calibration holds the output code static until it ends.
// - A self-clearing start bit launches foreground calibration.
// - Foreground calibration ends within a bound, longer with timing calibration.
// - A calibration start restarts the calibration logic at once.
// - Background mode powers five cores and rotates one offline at fixed rate.
// - Offset adjustment is ignored while background calibration is enabled.
// - Timing calibration is off after reset and runs with each calibration start.
package sycc_pkg;
    localparam logic [9:0] IDX_CAPTURE_CTRL = 10'h030;
    localparam logic [9:0] IDX_CAPTURE_FLAGS = 10'h031;
    localparam logic [9:0] IDX_DELAY = 10'h032;
    localparam logic [9:0] IDX_CAL_CTRL = 10'h050;
    localparam logic [9:0] IDX_CAL_MODE = 10'h057;
    localparam logic [9:0] IDX_TIMING_CAL = 10'h066;
    localparam logic [9:0] IDX_DECIMATION = 10'h070;
    localparam logic [9:0] IDX_OFFSET_ADJ = 10'h071;
    localparam logic [9:0] IDX_STATUS = 10'h072;
    localparam int BIT_INPUT_EN = 7;
    localparam int BIT_PROC_EN = 6;
    localparam int BIT_EDGE_CLR = 5;
    localparam int BIT_FAIL_CLR = 4;
    localparam int BIT_EDGE_SEEN = 7;
    localparam int BIT_CAP_FAIL = 6;
    localparam int BIT_CAL_START = 3;
    localparam int BIT_LINK_EN = 0;
    localparam int BIT_BG_SEL = 0;
    localparam int BIT_CONT_SEL = 1;
    localparam int BIT_TIMING_EN = 0;
    localparam int DELAY_W = 4;
    localparam logic [5:0] DECIM_RESET = 6'h01;
    localparam logic [11:0] OFFSET_RESET = 12'h000;
    localparam logic [14:0] CAL_HOLD_CODE = 15'h0000;
    localparam logic [4:0] CORES_FG = 5'h0F;
    localparam logic [4:0] CORES_BG = 5'h1F;
    localparam logic [2:0] CORE_LAST = 3'h4;
    localparam int FG_CYCLES = 102_000_000;
    localparam int FG_TIMING_CYCLES = 227_000_000;
    localparam int FG_BG_CYCLES = 127_500_000;
    localparam int FG_BG_TIMING_CYCLES = 283_750_000;
    localparam int BG_CYCLE_CYCLES = 816_000_000;
    localparam int BG_SLOT_CYCLES = BG_CYCLE_CYCLES / 5;
    localparam int CNT_W = 29;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_FG = 2'b01,
        CAL_BG = 2'b11
    } sycc_cal_type;
endpackage

//--- src/sycc_ctrl.sv
// Purpose: Sysref capture, output mode and calibration sequencing control.
// Assumes: All inputs are synchronous to clk; APB slave with 32-bit data.
// Notes: Register byte address is four times the register index.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
module sycc_ctrl #(
    parameter int FG_CYCLES = sycc_pkg::FG_CYCLES,
    parameter int FG_TIMING_CYCLES = sycc_pkg::FG_TIMING_CYCLES,
    parameter int FG_BG_CYCLES = sycc_pkg::FG_BG_CYCLES,
    parameter int FG_BG_TIMING_CYCLES = sycc_pkg::FG_BG_TIMING_CYCLES,
    parameter int BG_SLOT_CYCLES = sycc_pkg::BG_SLOT_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sysref_in,
    input wire logic sysref_margin_low,
    input wire logic link_ila_active,
    input wire logic [11:0] raw_sample,
    input wire logic [14:0] ddc_i,
    input wire logic [14:0] ddc_q,
    output logic [14:0] out_i,
    output logic [14:0] out_q,
    output logic out_valid,
    output logic out_complex,
    output logic sysref_capture_pulse,
    output logic nco_phase_reset,
    output logic serial_link_enable,
    output logic cal_busy,
    output logic timing_cal_run,
    output logic [4:0] cores_powered,
    output logic [2:0] offline_core,
    output logic [11:0] offset_adjust
);
    function automatic logic legal_factor(input logic [5:0] f);
        return f == 6'd1 || f == 6'd4 || f == 6'd8 || f == 6'd10 ||
            f == 6'd16 || f == 6'd20 || f == 6'd32;
    endfunction

    logic [31:0] prdata_q;
    logic pready_q, pslverr_q;
    logic [9:0] idx;
    logic mapped, wr_en;
    logic input_en_q, proc_en_q, edge_seen_q, cap_fail_q;
    logic [sycc_pkg::DELAY_W-1:0] delay_q;
    logic link_en_q, bg_sel_q, cont_sel_q, timing_en_q;
    logic [5:0] decim_q;
    logic [11:0] offset_q;
    logic [15:0] line_q;
    logic tap_q, tap_prev_q, edge_evt, fail_evt, edge_clr, fail_clr;
    logic start_evt;
    sycc_pkg::sycc_cal_type state_q;
    logic [sycc_pkg::CNT_W-1:0] cnt_q, limit;
    logic [2:0] offline_q;
    logic [5:0] dcnt_q;
    logic [14:0] out_i_q, out_q_q;
    logic out_valid_q, out_complex_q, pulse_q, nco_q, run_q;
    logic [4:0] cores_q;
    logic [11:0] offset_out_q;

    assign idx = paddr[11:2];
    assign mapped = idx == sycc_pkg::IDX_CAPTURE_CTRL ||
        idx == sycc_pkg::IDX_CAPTURE_FLAGS || idx == sycc_pkg::IDX_DELAY ||
        idx == sycc_pkg::IDX_CAL_CTRL || idx == sycc_pkg::IDX_CAL_MODE ||
        idx == sycc_pkg::IDX_TIMING_CAL || idx == sycc_pkg::IDX_DECIMATION ||
        idx == sycc_pkg::IDX_OFFSET_ADJ || idx == sycc_pkg::IDX_STATUS;
    assign wr_en = psel && penable && pready_q && pwrite && mapped;
    assign edge_clr = wr_en && idx == sycc_pkg::IDX_CAPTURE_CTRL &&
        pwdata[sycc_pkg::BIT_EDGE_CLR];
    assign fail_clr = wr_en && idx == sycc_pkg::IDX_CAPTURE_CTRL &&
        pwdata[sycc_pkg::BIT_FAIL_CLR];
    assign start_evt = wr_en && idx == sycc_pkg::IDX_CAL_CTRL &&
        pwdata[sycc_pkg::BIT_CAL_START];

    // The answer is prepared in the setup cycle so every access completes with no wait.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= psel && !penable;
            pslverr_q <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata_q <= 32'h0000_0000;
                if (!pwrite) begin
                    unique case (idx)
                        sycc_pkg::IDX_CAPTURE_CTRL: begin
                            prdata_q[sycc_pkg::BIT_INPUT_EN] <= input_en_q;
                            prdata_q[sycc_pkg::BIT_PROC_EN] <= proc_en_q;
                        end
                        sycc_pkg::IDX_CAPTURE_FLAGS: begin
                            prdata_q[sycc_pkg::BIT_EDGE_SEEN] <= edge_seen_q;
                            prdata_q[sycc_pkg::BIT_CAP_FAIL] <= cap_fail_q;
                        end
                        sycc_pkg::IDX_DELAY: prdata_q[3:0] <= delay_q;
                        sycc_pkg::IDX_CAL_CTRL:
                            prdata_q[sycc_pkg::BIT_LINK_EN] <= link_en_q;
                        sycc_pkg::IDX_CAL_MODE: begin
                            prdata_q[sycc_pkg::BIT_BG_SEL] <= bg_sel_q;
                            prdata_q[sycc_pkg::BIT_CONT_SEL] <= cont_sel_q;
                        end
                        sycc_pkg::IDX_TIMING_CAL:
                            prdata_q[sycc_pkg::BIT_TIMING_EN] <= timing_en_q;
                        sycc_pkg::IDX_DECIMATION: prdata_q[5:0] <= decim_q;
                        sycc_pkg::IDX_OFFSET_ADJ: prdata_q[11:0] <= offset_q;
                        sycc_pkg::IDX_STATUS:
                            prdata_q[5:0] <= {offline_q, state_q, cal_busy};
                        default: prdata_q <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

    // Start and clear bits are never stored.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            input_en_q <= 1'b0;
            proc_en_q <= 1'b0;
            delay_q <= '0;
            link_en_q <= 1'b0;
            bg_sel_q <= 1'b0;
            cont_sel_q <= 1'b0;
            timing_en_q <= 1'b0;
            decim_q <= sycc_pkg::DECIM_RESET;
            offset_q <= sycc_pkg::OFFSET_RESET;
        end else if (wr_en) begin
            unique case (idx)
                sycc_pkg::IDX_CAPTURE_CTRL: begin
                    input_en_q <= pwdata[sycc_pkg::BIT_INPUT_EN];
                    proc_en_q <= pwdata[sycc_pkg::BIT_PROC_EN];
                end
                sycc_pkg::IDX_DELAY: delay_q <= pwdata[3:0];
                sycc_pkg::IDX_CAL_CTRL:
                    link_en_q <= pwdata[sycc_pkg::BIT_LINK_EN];
                sycc_pkg::IDX_CAL_MODE: begin
                    bg_sel_q <= pwdata[sycc_pkg::BIT_BG_SEL];
                    cont_sel_q <= pwdata[sycc_pkg::BIT_CONT_SEL];
                end
                sycc_pkg::IDX_TIMING_CAL:
                    timing_en_q <= pwdata[sycc_pkg::BIT_TIMING_EN];
                sycc_pkg::IDX_DECIMATION: begin
                    // Unsupported factors are dropped so the rate stays legal.
                    if (legal_factor(pwdata[5:0])) begin
                        decim_q <= pwdata[5:0];
                    end
                end
                sycc_pkg::IDX_OFFSET_ADJ: offset_q <= pwdata[11:0];
                default: input_en_q <= input_en_q;
            endcase
        end
    end

    // The receiver enable gates the pin before the taps.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            line_q <= 16'h0000;
            tap_q <= 1'b0;
            tap_prev_q <= 1'b0;
        end else begin
            line_q <= {line_q[14:0], sysref_in && input_en_q};
            tap_q <= line_q[delay_q];
            tap_prev_q <= tap_q;
        end
    end

    assign edge_evt = proc_en_q && tap_q && !tap_prev_q;
    assign fail_evt = proc_en_q && input_en_q && sysref_margin_low;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_seen_q <= 1'b0;
            cap_fail_q <= 1'b0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= edge_evt;
            if (edge_evt) begin
                edge_seen_q <= 1'b1;
            end else if (edge_clr) begin
                edge_seen_q <= 1'b0;
            end
            if (fail_evt) begin
                cap_fail_q <= 1'b1;
            end else if (fail_clr) begin
                cap_fail_q <= 1'b0;
            end
        end
    end

    always_comb begin
        if (bg_sel_q && cont_sel_q) begin
            limit = timing_en_q ? sycc_pkg::CNT_W'(FG_BG_TIMING_CYCLES) :
                sycc_pkg::CNT_W'(FG_BG_CYCLES);
        end else begin
            limit = timing_en_q ? sycc_pkg::CNT_W'(FG_TIMING_CYCLES) :
                sycc_pkg::CNT_W'(FG_CYCLES);
        end
    end

    // A start in any state restarts the sequence at once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= sycc_pkg::CAL_IDLE;
            cnt_q <= '0;
            offline_q <= 3'h0;
            run_q <= 1'b0;
        end else if (start_evt) begin
            state_q <= sycc_pkg::CAL_FG;
            cnt_q <= '0;
            offline_q <= 3'h0;
            run_q <= timing_en_q;
        end else begin
            unique case (state_q)
                sycc_pkg::CAL_IDLE: cnt_q <= '0;
                sycc_pkg::CAL_FG: begin
                    if (cnt_q >= limit - 1'b1) begin
                        cnt_q <= '0;
                        run_q <= 1'b0;
                        state_q <= (bg_sel_q && cont_sel_q) ?
                            sycc_pkg::CAL_BG : sycc_pkg::CAL_IDLE;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                sycc_pkg::CAL_BG: begin
                    if (!(bg_sel_q && cont_sel_q)) begin
                        state_q <= sycc_pkg::CAL_IDLE;
                        cnt_q <= '0;
                    end else if (cnt_q >= sycc_pkg::CNT_W'(BG_SLOT_CYCLES - 1)) begin
                        cnt_q <= '0;
                        offline_q <= (offline_q == sycc_pkg::CORE_LAST) ?
                            3'h0 : offline_q + 3'h1;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: state_q <= sycc_pkg::CAL_IDLE;
            endcase
        end
    end

    // Foreground calibration freezes the code rather than passing noise.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dcnt_q <= 6'h00;
            out_i_q <= sycc_pkg::CAL_HOLD_CODE;
            out_q_q <= sycc_pkg::CAL_HOLD_CODE;
            out_valid_q <= 1'b0;
            out_complex_q <= 1'b0;
        end else if (state_q == sycc_pkg::CAL_FG || start_evt) begin
            dcnt_q <= 6'h00;
            out_i_q <= sycc_pkg::CAL_HOLD_CODE;
            out_q_q <= sycc_pkg::CAL_HOLD_CODE;
            out_valid_q <= 1'b0;
        end else if (decim_q == 6'd1) begin
            dcnt_q <= 6'h00;
            out_i_q <= {3'b000, raw_sample};
            out_q_q <= 15'h0000;
            out_valid_q <= 1'b1;
            out_complex_q <= 1'b0;
        end else begin
            out_complex_q <= 1'b1;
            out_valid_q <= dcnt_q == decim_q - 6'd1;
            dcnt_q <= (dcnt_q == decim_q - 6'd1) ? 6'h00 : dcnt_q + 6'h01;
            if (dcnt_q == decim_q - 6'd1) begin
                out_i_q <= ddc_i;
                out_q_q <= ddc_q;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nco_q <= 1'b0;
            cores_q <= sycc_pkg::CORES_FG;
            offset_out_q <= sycc_pkg::OFFSET_RESET;
        end else begin
            nco_q <= link_ila_active && decim_q != 6'd1;
            cores_q <= (state_q == sycc_pkg::CAL_BG) ?
                sycc_pkg::CORES_BG : sycc_pkg::CORES_FG;
            offset_out_q <= (bg_sel_q && cont_sel_q) ?
                sycc_pkg::OFFSET_RESET : offset_q;
        end
    end

    assign cal_busy = state_q == sycc_pkg::CAL_FG;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign out_i = out_i_q;
    assign out_q = out_q_q;
    assign out_valid = out_valid_q;
    assign out_complex = out_complex_q;
    assign sysref_capture_pulse = pulse_q;
    assign nco_phase_reset = nco_q;
    assign serial_link_enable = link_en_q;
    assign timing_cal_run = run_q;
    assign cores_powered = cores_q;
    assign offline_core = offline_q;
    assign offset_adjust = offset_out_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence edge_capture_s;
        proc_en_q && tap_q && !tap_prev_q;
    endsequence

    edge_set_a: assert property (edge_capture_s |=> edge_seen_q && pulse_q)
        else $error("edge flag not set");
    edge_sticky_a: assert property (edge_seen_q && !edge_clr |=> edge_seen_q)
        else $error("edge flag cleared itself");
    set_wins_a: assert property (fail_evt && fail_clr |=> cap_fail_q)
        else $error("failure event lost");
    fail_set_a: assert property (fail_evt |=> cap_fail_q)
        else $error("failure flag not set");
    flag_clear_a: assert property (edge_clr && !edge_evt |=> !edge_seen_q)
        else $error("edge flag not cleared");
    delay_path_a: assert property (
        delay_q == 4'h0 && input_en_q && $stable(delay_q) ##1
        input_en_q |=> tap_q == $past(sysref_in, 2))
        else $error("tap misaligned");

    sequence cal_launch_s;
        start_evt ##1 cal_busy;
    endsequence

    cal_start_a: assert property (start_evt |-> cal_launch_s)
        else $error("no start");
    cal_hold_a: assert property (cal_busy |=> !out_valid && out_i == 15'h0000)
        else $error("output not frozen");
    cal_bound_a: assert property (cal_busy |-> cnt_q < limit)
        else $error("calibration too long");
    bypass_rate_a: assert property (!cal_busy && !start_evt &&
        decim_q == 6'd1 |=> out_valid && !out_complex)
        else $error("no bypass sample");
    nco_reset_a: assert property (
        link_ila_active && decim_q != 6'd1 |=> nco_phase_reset)
        else $error("nco not reset");
    bg_cores_a: assert property (
        state_q == sycc_pkg::CAL_BG |=> cores_powered == 5'h1F
        || $past(start_evt))
        else $error("not five cores");
    offset_ignore_a: assert property (
        bg_sel_q && cont_sel_q |=> offset_adjust == 12'h000)
        else $error("offset not ignored");
    timing_run_a: assert property (timing_cal_run |-> cal_busy)
        else $error("timing run outside calibration");
endmodule // sycc_ctrl

//--- verification/sycc_far_end.sv
// Purpose: Far-side model: sysref source and link alignment driver.
// Assumes: Sysref is made from the device clock with a fixed phase.
// Notes: Sysref stays low unless the bench turns the source on.
`timescale 1ns/100ps
module sycc_far_end #(
    parameter int PERIOD = 32
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sysref_on,
    input wire logic ila_req,
    output logic sysref_in,
    output logic link_ila_active
);
    int cnt;
    // A counter keeps the pulse a fixed subharmonic with repeatable phase.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            sysref_in <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sysref_in <= sysref_on && (cnt < 4);
        end
    end
    // Alignment follows every sync request one cycle later.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            link_ila_active <= 1'b0;
        end else begin
            link_ila_active <= ila_req;
        end
    end
endmodule // sycc_far_end

//--- verification/test_sysref_capture_and_calibration_ctrl.sv
// Purpose: Self-checking bench for the sysref and calibration controller.
// Assumes: Calibration counts are shortened to 20, 30, 25, 35 and 10.
// Notes: Each scenario task drives and judges by itself.
`timescale 1ns/100ps
`define CHK(nm, ex, ac) begin total_checks++; if ((ac) !== (ex)) begin \
    n_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, ac); \
    end end
module test_sysref_capture_and_calibration_ctrl;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, sysref_in, link_ila_active, out_valid;
    logic margin_low = 1'b0;
    logic sysref_on = 1'b0;
    logic ila_req = 1'b0;
    logic [11:0] raw = 12'h000;
    logic [14:0] out_i, out_q;
    logic out_complex, cap_pulse, nco_rst, link_en, cal_busy, tcal;
    logic [4:0] cores;
    logic [2:0] offl;
    logic [11:0] offs;
    int n_errors = 0;
    int total_checks = 0;
    always #5 clk = ~clk;
    always @(posedge clk) raw <= raw + 12'h001;
    sycc_ctrl #(.FG_CYCLES(20), .FG_TIMING_CYCLES(30), .FG_BG_CYCLES(25),
        .FG_BG_TIMING_CYCLES(35), .BG_SLOT_CYCLES(10)) u_sycc_ctrl (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sysref_in(sysref_in),
        .sysref_margin_low(margin_low), .link_ila_active(link_ila_active),
        .raw_sample(raw), .ddc_i({3'h0, raw}), .ddc_q({raw, 3'h0}),
        .out_i(out_i), .out_q(out_q), .out_valid(out_valid),
        .out_complex(out_complex), .sysref_capture_pulse(cap_pulse),
        .nco_phase_reset(nco_rst), .serial_link_enable(link_en),
        .cal_busy(cal_busy), .timing_cal_run(tcal), .cores_powered(cores),
        .offline_core(offl), .offset_adjust(offs));
    sycc_far_end u_sycc_far_end (.clk(clk), .rst_n(rst_n),
        .sysref_on(sysref_on), .ila_req(ila_req), .sysref_in(sysref_in),
        .link_ila_active(link_ila_active));
    task automatic apb(input logic w, input logic [9:0] idx,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) n_errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] r;
        logic e;
        apb(1'b1, idx, wd, r, e);
    endtask
    task automatic rd(input logic [9:0] idx, output logic [31:0] r);
        logic e;
        apb(1'b0, idx, 32'h0000_0000, r, e);
    endtask
    task automatic t_reset;
        logic [31:0] r;
        logic e;
        rd(sycc_pkg::IDX_CAPTURE_CTRL, r);
        `CHK("ctrl reset", 32'h0000_0000, r)
        rd(sycc_pkg::IDX_TIMING_CAL, r);
        `CHK("timing reset", 32'h0000_0000, r)
        apb(1'b0, 10'h3FF, 32'h0000_0000, r, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("cores reset", 5'h0F, cores)
        $display("test reset done");
    endtask
    task automatic t_capture(input logic [3:0] d);
        logic [31:0] r;
        int n;
        begin
            wr(sycc_pkg::IDX_DELAY, {28'h000_0000, d});
            wr(sycc_pkg::IDX_CAPTURE_CTRL, 32'h0000_00F0);
            rd(sycc_pkg::IDX_CAPTURE_CTRL, r);
            `CHK("ctrl readback", 32'h0000_00C0, r)
            sysref_on <= 1'b1;
            n = 0;
            while (sysref_in !== 1'b1 && n < 100) begin
                @(posedge clk);
                n++;
            end
            n = 0;
            while (cap_pulse !== 1'b1 && n < 40) begin
                @(posedge clk);
                n++;
            end
            sysref_on <= 1'b0;
            `CHK("capture delay", 3 + d, n)
            repeat (40) @(posedge clk);
            rd(sycc_pkg::IDX_CAPTURE_FLAGS, r);
            `CHK("edge sticky", 1'b1, r[7])
            wr(sycc_pkg::IDX_CAPTURE_CTRL, 32'h0000_00E0);
            rd(sycc_pkg::IDX_CAPTURE_FLAGS, r);
            `CHK("edge cleared", 1'b0, r[7])
            $display("test capture done");
        end
    endtask
    task automatic t_fail;
        logic [31:0] r;
        int n;
        begin
            margin_low <= 1'b1;
            @(posedge clk);
            margin_low <= 1'b0;
            repeat (20) @(posedge clk);
            rd(sycc_pkg::IDX_CAPTURE_FLAGS, r);
            `CHK("fail sticky", 1'b1, r[6])
            margin_low <= 1'b1;
            wr(sycc_pkg::IDX_CAPTURE_CTRL, 32'h0000_00D0);
            margin_low <= 1'b0;
            rd(sycc_pkg::IDX_CAPTURE_FLAGS, r);
            `CHK("set beats clear", 1'b1, r[6])
            wr(sycc_pkg::IDX_CAPTURE_CTRL, 32'h0000_0010);
            rd(sycc_pkg::IDX_CAPTURE_FLAGS, r);
            `CHK("fail cleared", 1'b0, r[6])
            sysref_on <= 1'b1;
            margin_low <= 1'b1;
            n = 0;
            repeat (70) begin
                @(posedge clk);
                if (cap_pulse === 1'b1) n++;
            end
            sysref_on <= 1'b0;
            margin_low <= 1'b0;
            `CHK("disabled pulses", 0, n)
            rd(sycc_pkg::IDX_CAPTURE_FLAGS, r);
            `CHK("disabled flags", 2'b00, r[7:6])
            $display("test fail flag done");
        end
    endtask
    task automatic t_decim;
        int f[7] = '{1, 4, 8, 10, 16, 20, 32};
        int n;
        logic [31:0] r;
        foreach (f[k]) begin
            wr(sycc_pkg::IDX_DECIMATION, f[k]);
            repeat (40) @(posedge clk);
            n = 0;
            repeat (f[k] * 4) begin
                @(posedge clk);
                if (out_valid === 1'b1) n++;
                if (out_valid === 1'b1 && f[k] > 1)
                    `CHK("q", {raw - 12'h001, 3'h0}, out_q)
            end
            `CHK("valid rate", 4, n)
            `CHK("complex", f[k] != 1, out_complex)
        end
        wr(sycc_pkg::IDX_DECIMATION, 32'h0000_0005);
        rd(sycc_pkg::IDX_DECIMATION, r);
        `CHK("bad factor", 32'h0000_0020, r)
        ila_req <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK("nco reset", 1'b1, nco_rst)
        wr(sycc_pkg::IDX_DECIMATION, 32'h0000_0001);
        repeat (4) @(posedge clk);
        `CHK("nco bypass", 1'b0, nco_rst)
        ila_req <= 1'b0;
        $display("test decimation done");
    endtask
    task automatic t_cal(input logic tm, input logic rs);
        logic [31:0] r;
        int n;
        logic bad, tr;
        begin
            wr(sycc_pkg::IDX_TIMING_CAL, {31'h0000_0000, tm});
            wr(sycc_pkg::IDX_CAL_CTRL, 32'h0000_0009);
            if (rs) begin
                repeat (8) @(posedge clk);
                wr(sycc_pkg::IDX_CAL_CTRL, 32'h0000_0009);
            end
            n = 0;
            bad = 1'b0;
            tr = 1'b0;
            while (cal_busy === 1'b1 && n < 100) begin
                if (out_valid !== 1'b0 || out_i !== 15'h0000) bad = 1'b1;
                if (tcal === 1'b1) tr = 1'b1;
                n++;
                @(posedge clk);
            end
            `CHK("cal length", tm ? 30 : 20, n)
            `CHK("static output", 1'b0, bad)
            `CHK("timing run", tm, tr)
            rd(sycc_pkg::IDX_CAL_CTRL, r);
            `CHK("start clears", 32'h0000_0001, r)
            wr(sycc_pkg::IDX_CAL_CTRL, 32'h0000_0000);
            `CHK("link off", 1'b0, link_en)
            wr(sycc_pkg::IDX_CAL_CTRL, 32'h0000_0001);
            `CHK("data back", 1'b1, out_valid)
            $display("test calibration done");
        end
    endtask
    task automatic t_bg;
        logic [2:0] o, p;
        logic bad;
        int n;
        begin
            wr(sycc_pkg::IDX_OFFSET_ADJ, 32'h0000_0123);
            @(posedge clk);
            `CHK("offset used", 12'h123, offs)
            wr(sycc_pkg::IDX_CAL_MODE, 32'h0000_0003);
            wr(sycc_pkg::IDX_CAL_CTRL, 32'h0000_0009);
            n = 0;
            while (cores !== 5'h1F && n < 200) begin
                @(posedge clk);
                n++;
            end
            `CHK("five cores", 5'h1F, cores)
            `CHK("offset ignored", 12'h000, offs)
            o = offl;
            n = 0;
            while (offl === o && n < 50) begin
                @(posedge clk);
                n++;
            end
            o = offl;
            p = o;
            bad = 1'b0;
            repeat (5) @(posedge clk);
            repeat (5) begin
                repeat (10) @(posedge clk);
                if (offl === p || offl > 3'h4) bad = 1'b1;
                p = offl;
            end
            `CHK("rotation step", 1'b0, bad)
            `CHK("rotation cycle", o, p)
            wr(sycc_pkg::IDX_CAL_MODE, 32'h0000_0000);
            wr(sycc_pkg::IDX_CAL_CTRL, 32'h0000_0009);
            repeat (60) @(posedge clk);
            `CHK("four cores", 5'h0F, cores)
            `CHK("offset back", 12'h123, offs)
            $display("test background done");
        end
    endtask
    task complete_run;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // The run needs about 1300 cycles; 30000 means a hang.
    initial begin
        #300_000;
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_capture(4'h0);
        t_capture(4'hF);
        t_fail();
        t_decim();
        t_cal(1'b0, 1'b0);
        t_cal(1'b1, 1'b0);
        t_cal(1'b0, 1'b1);
        t_bg();
        complete_run();
    end
endmodule // test_sysref_capture_and_calibration_ctrl
